// ==== hdl/fdcpm_pkg.sv ====
// Constants shared by the drive-mode and sector-read command logic.
// Assumes one 20 MHz clock and bytes handed in one at a time by the host side.
package fdcpm_pkg;
    localparam logic [7:0] OPC_VERSION = 8'h18;
    localparam logic [7:0] OPC_DRIVE_MODE = 8'h12;
    localparam logic [4:0] OPC_READ_LOW = 5'h06;
    localparam logic [7:0] VERSION_HIGH = 8'h70; // Arbitrary value
    localparam logic [3:0] VERSION_LOW = 4'h1; // Arbitrary value
    localparam logic [7:0] INVALID_RESULT = 8'h80;
    localparam logic [7:0] TRACK_BAD = 8'hFF;
    localparam int READ_BYTES = 9;
    localparam logic [5:0] GAP2_FMT_PERP = 6'h29;
    localparam logic [5:0] GAP2_FMT_CONV = 6'h16;
    localparam logic [5:0] GAP2_WR_FAST = 6'h26;
    localparam logic [5:0] GAP2_WR_SLOW = 6'h13;
    localparam logic [5:0] GAP2_WR_NONE = 6'h00;
    localparam logic [1:0] GROUP_PERP_SLOW = 2'h1;
    localparam logic [1:0] GROUP_PERP_FAST = 2'h3;
    localparam logic [1:0] TERM_NORMAL = 2'h0;
    localparam logic [1:0] TERM_ABNORMAL = 2'h1;
    localparam logic [1:0] TERM_INVALID = 2'h2;
    localparam int ST1_EOT_BIT = 7;
    localparam int ST1_CRC_BIT = 5;
    localparam int ST1_OVERRUN_BIT = 4;
    localparam int ST1_MISSING_DATA_BIT = 2;
    localparam int ST1_MISSING_AM_BIT = 0;
    localparam int ST2_CRC_DATA_BIT = 5;
    localparam int ST2_WRONG_TRACK_BIT = 4;
    localparam int ST2_BAD_TRACK_BIT = 1;
    localparam int INDEX_LIMIT = 2;
endpackage

// ==== hdl/fdcpm_mode_if.sv ====
// Drive-mode configuration bundle between command logic and mode store.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface fdcpm_mode_if;
    logic wr;
    logic [7:0] data;
    logic [1:0] group;
    logic [3:0] per_drive;
    modport ctrl (output wr, output data, input group, input per_drive);
    modport store (input wr, input data, output group, output per_drive);
endinterface
`default_nettype wire

// ==== hdl/fdcpm_mode_store.sv ====
// Drive-mode configuration store for four logical drives.
// Assumes software reset arrives as a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module fdcpm_mode_store (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_soft_rst,
    fdcpm_mode_if.store mif
);
    always_ff @(posedge i_clock) begin
        if (i_rst || i_soft_rst) begin
            mif.group <= 2'h0;
        end else if (mif.wr) begin
            mif.group <= mif.data[1:0];
        end
    end

    // Software reset leaves these alone
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mif.per_drive <= 4'h0;
        end else if (mif.wr && mif.data[7]) begin
            mif.per_drive <= mif.data[5:2];
        end
    end
endmodule
`default_nettype wire

// ==== hdl/fdcpm_drive_params.sv ====
// Per-drive format and write parameters from mode and data rate.
// Assumes a two-bit drive number and a fast-rate flag for 1 or 2 Mbps.
`timescale 1ns/1ps
`default_nettype none
module fdcpm_drive_params (
    input wire logic [1:0] i_group,
    input wire logic [3:0] i_per_drive,
    input wire logic [1:0] i_drive,
    input wire logic i_fast_rate,
    output logic o_perp,
    output logic [5:0] o_gap2_fmt,
    output logic [5:0] o_gap2_wr,
    output logic o_precomp_zero
);
    always_comb begin
        if (i_group != 2'h0) begin
            o_perp = i_group[0];
        end else begin
            o_perp = i_per_drive[i_drive];
        end
        o_gap2_fmt = (o_perp && i_fast_rate) ? fdcpm_pkg::GAP2_FMT_PERP
                                             : fdcpm_pkg::GAP2_FMT_CONV;
        if (!o_perp) begin
            o_gap2_wr = fdcpm_pkg::GAP2_WR_NONE;
        end else if (i_fast_rate) begin
            o_gap2_wr = fdcpm_pkg::GAP2_WR_FAST;
        end else begin
            o_gap2_wr = fdcpm_pkg::GAP2_WR_SLOW;
        end
        o_precomp_zero = o_perp;
    end
endmodule
`default_nettype wire

// ==== hdl/fdcpm_cmd.sv ====
// Command interpreter: version query, drive mode and sector read.
// Assumes host bytes arrive as one-cycle strobes; disk events are
// one-cycle pulses from the data separator side.
`timescale 1ns/1ps
`default_nettype none
module fdcpm_cmd #(
    parameter int DBP_CYCLES = 16,
    parameter int SETTLE_CYCLES = 16
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_soft_rst,
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_data,
    input wire logic i_result_rd,
    input wire logic i_fast_rate,
    input wire logic i_seek_done,
    input wire logic i_id_valid,
    input wire logic [7:0] i_id_track,
    input wire logic [7:0] i_id_head,
    input wire logic [7:0] i_id_sector,
    input wire logic [7:0] i_id_size,
    input wire logic i_index_pulse,
    input wire logic i_data_deleted,
    input wire logic i_sector_done,
    input wire logic i_dma_tc,
    input wire logic i_overrun,
    input wire logic i_crc_err,
    input wire logic i_no_am,
    output logic o_result_valid,
    output logic [7:0] o_result_data,
    output logic o_controller_irq,
    output logic o_busy,
    output logic o_side_select_out,
    output logic [1:0] o_drive_sel,
    output logic o_seek_req,
    output logic o_sep_enable,
    output logic o_sector_xfer,
    output logic o_double_density_enc,
    output logic [5:0] o_gap2_fmt,
    output logic [5:0] o_gap2_wr,
    output logic o_precomp_zero,
    output logic o_drive_perp
);
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_PARAM = 8'h02,
        S_DELAY = 8'h04,
        S_SEEK = 8'h08,
        S_SETTLE = 8'h10,
        S_SEARCH = 8'h20,
        S_XFER = 8'h40,
        S_RESULT = 8'h80
    } fdcpm_state_e;

    fdcpm_state_e state;
    fdcpm_mode_if mif();
    logic [7:0] cmd_bytes [0:fdcpm_pkg::READ_BYTES-1];
    logic [3:0] byte_idx;
    logic [15:0] wait_cnt;
    logic [1:0] index_cnt;
    logic [2:0] res_idx;
    logic [2:0] res_len;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] single_res;
    logic skip_sector;
    logic multi_side;
    logic deleted_sector_bypass;
    logic auto_seek_flag;
    logic head_side;
    logic id_match;
    logic id_rest_match;
    logic at_last;
    logic next_perp;
    logic [5:0] next_gap2_fmt;
    logic [5:0] next_gap2_wr;
    logic next_precomp_zero;
    logic [7:0] next_result;

    fdcpm_mode_store u_store (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_soft_rst(i_soft_rst),
        .mif(mif.store)
    );

    fdcpm_drive_params u_params (
        .i_group(mif.group),
        .i_per_drive(mif.per_drive),
        .i_drive(o_drive_sel),
        .i_fast_rate(i_fast_rate),
        .o_perp(next_perp),
        .o_gap2_fmt(next_gap2_fmt),
        .o_gap2_wr(next_gap2_wr),
        .o_precomp_zero(next_precomp_zero)
    );

    assign mif.wr = (state == S_PARAM) && i_cmd_wr && !cmd_bytes[0][2];
    assign mif.data = i_cmd_data;

    assign multi_side = cmd_bytes[0][7];
    assign deleted_sector_bypass = cmd_bytes[0][5];
    assign auto_seek_flag = cmd_bytes[1][7];
    assign head_side = cmd_bytes[1][2];
    assign id_rest_match = (i_id_head == cmd_bytes[3]) && (i_id_sector == cmd_bytes[4])
        && (i_id_size == cmd_bytes[5]);
    assign id_match = (i_id_track == cmd_bytes[2]) && id_rest_match;
    assign at_last = (cmd_bytes[4] == cmd_bytes[6]);
    assign skip_sector = i_data_deleted && deleted_sector_bypass;

    // Eight-bit status bytes, then ID bytes
    always_comb begin
        next_result = 8'h00;
        unique case (res_idx)
            3'd0: next_result = (res_len == 3'd1) ? single_res : st0;
            3'd1: next_result = st1;
            3'd2: next_result = st2;
            3'd3: next_result = cmd_bytes[2];
            3'd4: next_result = cmd_bytes[3];
            3'd5: next_result = cmd_bytes[4];
            3'd6: next_result = cmd_bytes[5];
            default: next_result = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock) begin
        o_gap2_fmt <= next_gap2_fmt;
        o_gap2_wr <= next_gap2_wr;
        o_precomp_zero <= next_precomp_zero;
        o_drive_perp <= next_perp;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= S_IDLE;
            byte_idx <= 4'h0;
            wait_cnt <= 16'h0000;
            index_cnt <= 2'h0;
            res_idx <= 3'h0;
            res_len <= 3'h0;
            st0 <= 8'h00;
            st1 <= 8'h00;
            st2 <= 8'h00;
            single_res <= 8'h00;
            for (int i = 0; i < fdcpm_pkg::READ_BYTES; i++) begin
                cmd_bytes[i] <= 8'h00;
            end
        end else if (i_soft_rst) begin
            state <= S_IDLE;
            byte_idx <= 4'h0;
            cmd_bytes[1] <= 8'h00;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (i_cmd_wr) begin
                        cmd_bytes[0] <= i_cmd_data;
                        byte_idx <= 4'h1;
                        res_idx <= 3'h0;
                        st0 <= 8'h00;
                        st1 <= 8'h00;
                        st2 <= 8'h00;
                        if (i_cmd_data == fdcpm_pkg::OPC_VERSION) begin
                            single_res <= fdcpm_pkg::VERSION_HIGH
                                | {4'h0, fdcpm_pkg::VERSION_LOW};
                            res_len <= 3'd1;
                            state <= S_RESULT;
                        end else if (i_cmd_data == fdcpm_pkg::OPC_DRIVE_MODE
                            || i_cmd_data[4:0] == fdcpm_pkg::OPC_READ_LOW) begin
                            state <= S_PARAM;
                        end else begin
                            single_res <= fdcpm_pkg::INVALID_RESULT;
                            res_len <= 3'd1;
                            state <= S_RESULT;
                        end
                    end
                end
                S_PARAM: begin
                    if (i_cmd_wr) begin
                        cmd_bytes[byte_idx] <= i_cmd_data;
                        byte_idx <= byte_idx + 4'h1;
                        if (!cmd_bytes[0][2]) begin
                            state <= S_IDLE;
                        end else if (byte_idx == 4'(fdcpm_pkg::READ_BYTES - 1)) begin
                            wait_cnt <= 16'(DBP_CYCLES);
                            state <= S_DELAY;
                        end
                    end
                end
                default: begin
                    if (i_cmd_wr && state != S_RESULT) begin
                        st0[7:6] <= fdcpm_pkg::TERM_ABNORMAL;
                        res_len <= 3'd7;
                        state <= S_RESULT;
                    end else begin
                        unique case (state)
                            S_DELAY: begin
                                if (wait_cnt != 16'h0000) begin
                                    wait_cnt <= wait_cnt - 16'h0001;
                                end else if (auto_seek_flag) begin
                                    state <= S_SEEK;
                                end else begin
                                    index_cnt <= 2'h0;
                                    state <= S_SEARCH;
                                end
                            end
                            S_SEEK: begin
                                if (i_seek_done) begin
                                    wait_cnt <= 16'(SETTLE_CYCLES);
                                    state <= S_SETTLE;
                                end
                            end
                            S_SETTLE: begin
                                if (wait_cnt != 16'h0000) begin
                                    wait_cnt <= wait_cnt - 16'h0001;
                                end else begin
                                    index_cnt <= 2'h0;
                                    state <= S_SEARCH;
                                end
                            end
                            S_SEARCH: begin
                                if (i_id_valid && id_match) begin
                                    state <= S_XFER;
                                end else if (i_index_pulse) begin
                                    index_cnt <= index_cnt + 2'h1;
                                    if (index_cnt == 2'(fdcpm_pkg::INDEX_LIMIT - 1)) begin
                                        st0[7:6] <= fdcpm_pkg::TERM_ABNORMAL;
                                        if (i_id_track == fdcpm_pkg::TRACK_BAD) begin
                                            st2[fdcpm_pkg::ST2_BAD_TRACK_BIT] <= 1'b1;
                                        end else if (i_id_track != cmd_bytes[2]) begin
                                            st2[fdcpm_pkg::ST2_WRONG_TRACK_BIT] <= 1'b1;
                                        end
                                        if (i_no_am) begin
                                            st1[fdcpm_pkg::ST1_MISSING_AM_BIT] <= 1'b1;
                                        end else begin
                                            st1[fdcpm_pkg::ST1_MISSING_DATA_BIT] <= 1'b1;
                                        end
                                        res_len <= 3'd7;
                                        state <= S_RESULT;
                                    end
                                end
                            end
                            S_XFER: begin
                                if (i_dma_tc) begin
                                    st0[7:6] <= fdcpm_pkg::TERM_NORMAL;
                                    res_len <= 3'd7;
                                    state <= S_RESULT;
                                end else if (i_overrun) begin
                                    st0[7:6] <= fdcpm_pkg::TERM_ABNORMAL;
                                    st1[fdcpm_pkg::ST1_OVERRUN_BIT] <= 1'b1;
                                    res_len <= 3'd7;
                                    state <= S_RESULT;
                                end else if (i_crc_err) begin
                                    st0[7:6] <= fdcpm_pkg::TERM_ABNORMAL;
                                    st1[fdcpm_pkg::ST1_CRC_BIT] <= 1'b1;
                                    st2[fdcpm_pkg::ST2_CRC_DATA_BIT] <= 1'b1;
                                    res_len <= 3'd7;
                                    state <= S_RESULT;
                                end else if (i_sector_done || (i_data_deleted && skip_sector)) begin
                                    if (!at_last) begin
                                        cmd_bytes[4] <= cmd_bytes[4] + 8'h01;
                                        index_cnt <= 2'h0;
                                        state <= S_SEARCH;
                                    end else if (multi_side && !head_side) begin
                                        cmd_bytes[1][2] <= 1'b1;
                                        cmd_bytes[3] <= 8'h01;
                                        cmd_bytes[4] <= 8'h01;
                                        index_cnt <= 2'h0;
                                        state <= S_SEARCH;
                                    end else begin
                                        st0[7:6] <= fdcpm_pkg::TERM_ABNORMAL;
                                        st1[fdcpm_pkg::ST1_EOT_BIT] <= 1'b1;
                                        res_len <= 3'd7;
                                        state <= S_RESULT;
                                    end
                                end
                            end
                            default: state <= S_IDLE;
                        endcase
                    end
                end
                S_RESULT: begin
                    if (i_result_rd) begin
                        if (res_idx == res_len - 3'd1) begin
                            state <= S_IDLE;
                        end else begin
                            res_idx <= res_idx + 3'd1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_result_valid <= 1'b0;
            o_result_data <= 8'h00;
            o_controller_irq <= 1'b0;
            o_busy <= 1'b0;
            o_side_select_out <= 1'b0;
            o_drive_sel <= 2'h0;
            o_seek_req <= 1'b0;
            o_sep_enable <= 1'b0;
            o_sector_xfer <= 1'b0;
            o_double_density_enc <= 1'b0;
        end else begin
            o_result_valid <= (state == S_RESULT);
            o_result_data <= next_result;
            // Irq only for commands with an execution phase
            o_controller_irq <= (state == S_RESULT) && (res_len == 3'd7) && (res_idx == 3'd0);
            o_busy <= (state != S_IDLE);
            o_side_select_out <= head_side;
            o_drive_sel <= cmd_bytes[1][1:0];
            o_seek_req <= (state == S_SEEK);
            o_sep_enable <= (state == S_SEARCH) || (state == S_XFER);
            o_sector_xfer <= (state == S_XFER);
            o_double_density_enc <= cmd_bytes[0][6];
        end
    end
endmodule
`default_nettype wire

// ==== testbench/fdcpm_chk.sv ====
// Port-level assertions for the command interpreter.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fdcpm_chk #(
    parameter int DBP_CYCLES = 16,
    parameter int SETTLE_CYCLES = 16
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cmd_wr,
    input wire logic [7:0] i_cmd_data,
    input wire logic i_seek_done,
    input wire logic o_result_valid,
    input wire logic [7:0] o_result_data,
    input wire logic o_controller_irq,
    input wire logic o_busy,
    input wire logic o_seek_req,
    input wire logic o_sep_enable,
    input wire logic [5:0] o_gap2_fmt,
    input wire logic [5:0] o_gap2_wr,
    input wire logic o_precomp_zero,
    input wire logic o_drive_perp
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic [7:0] since_wr;
    // Saturates so a long search cannot wrap into a false short wait
    always_ff @(posedge i_clock) begin
        if (i_rst || i_cmd_wr) begin
            since_wr <= 8'h00;
        end else if (since_wr != 8'hFF) begin
            since_wr <= since_wr + 8'h01;
        end
    end
    sequence s_seek_end;
        o_seek_req && i_seek_done;
    endsequence
    sequence s_settle;
        !o_sep_enable [*4];
    endsequence
    a_version_reply: assert property (!o_busy && !o_result_valid && i_cmd_wr &&
        i_cmd_data == fdcpm_pkg::OPC_VERSION |-> ##2 o_result_valid &&
        o_result_data[3:0] == fdcpm_pkg::VERSION_LOW)
        else $error("version byte missing or wrong");
    a_invalid_reply: assert property (!o_busy && !o_result_valid && i_cmd_wr &&
        i_cmd_data != fdcpm_pkg::OPC_VERSION && i_cmd_data != fdcpm_pkg::OPC_DRIVE_MODE &&
        i_cmd_data[4:0] != fdcpm_pkg::OPC_READ_LOW |-> ##2 o_result_valid &&
        o_result_data == fdcpm_pkg::INVALID_RESULT)
        else $error("unknown opcode not refused");
    a_dbp_wait: assert property ($rose(o_sep_enable) |-> since_wr >= DBP_CYCLES)
        else $error("search started before the processing delay");
    a_settle_wait: assert property (s_seek_end |=> s_settle)
        else $error("search started before head settle");
    a_gap2_pair: assert property (o_gap2_wr == 6'h26 |-> o_gap2_fmt == 6'h29 && o_drive_perp)
        else $error("fast perpendicular gap lengths inconsistent");
    a_precomp_perp: assert property (o_drive_perp |-> o_precomp_zero)
        else $error("precompensation not zero on perpendicular drive");
    a_irq_result: assert property ($rose(o_controller_irq) |-> ##[0:2] o_result_valid)
        else $error("interrupt without result phase");
    a_abort_write: assert property (o_sep_enable && i_cmd_wr |-> ##[1:4] o_result_valid)
        else $error("host write did not abort execution");
endmodule
bind fdcpm_cmd fdcpm_chk #(.DBP_CYCLES(DBP_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .i_clock, .i_rst, .i_cmd_wr, .i_cmd_data, .i_seek_done, .o_result_valid, .o_result_data,
    .o_controller_irq, .o_busy, .o_seek_req, .o_sep_enable, .o_gap2_fmt, .o_gap2_wr,
    .o_precomp_zero, .o_drive_perp);
`default_nettype wire

// ==== testbench/fdcpm_host.sv ====
// Host processor model: writes command bytes, reads result bytes.
// Assumes callers use one task at a time, starting at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module fdcpm_host (
    input wire logic i_clock,
    input wire logic i_result_valid,
    input wire logic [7:0] i_result_data,
    output logic o_cmd_wr,
    output logic [7:0] o_cmd_data,
    output logic o_result_rd
);
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd_data = 8'h00;
        o_result_rd = 1'b0;
    end
    // Released data is inverted so a stale byte is never mistaken
    task automatic send(input logic [7:0] b);
        @(negedge i_clock);
        o_cmd_wr = 1'b1;
        o_cmd_data = b;
        @(negedge i_clock);
        o_cmd_wr = 1'b0;
        o_cmd_data = ~b;
    endtask
    task automatic recv(output logic [7:0] b);
        int n;
        n = 0;
        while (i_result_valid !== 1'b1 && n < 400) begin
            @(negedge i_clock);
            n++;
        end
        b = (i_result_valid === 1'b1) ? i_result_data : 8'hXX;
        @(negedge i_clock);
        o_result_rd = 1'b1;
        @(negedge i_clock);
        o_result_rd = 1'b0;
        repeat (2) @(negedge i_clock);
    endtask
    task automatic read_cmd(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] trk);
        send(op);
        send(b2);
        send(trk);
        send({7'h00, b2[2]});
        send(8'h01);
        send(8'h02);
        send(8'h01);
        send(8'h1B);
        send(8'hFF);
    endtask
endmodule
`default_nettype wire

// ==== testbench/fdcpm_cmd_tb.sv ====
// Self-checking bench for the command interpreter top.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module fdcpm_cmd_tb;
    localparam logic [7:0] CFG [8] = '{8'h03, 8'h03, 8'h02, 8'h01, 8'h84, 8'h00, 8'h86, 8'h01};
    localparam logic [7:0] FAST = 8'h75;
    localparam logic [5:0] FMT [8] = '{6'h29, 6'h16, 6'h16, 6'h16, 6'h29, 6'h29, 6'h16, 6'h16};
    localparam logic [5:0] WR [8] = '{6'h26, 6'h13, 6'h00, 6'h13, 6'h26, 6'h26, 6'h00, 6'h13};
    localparam logic [7:0] OP [8] = '{8'hE6, 8'h46, 8'h06, 8'hC6, 8'h66, 8'h26, 8'hA6, 8'h86};
    localparam logic [7:0] B2 [8] = '{8'h82, 8'h01, 8'h02, 8'h03, 8'h00, 8'h06, 8'h81, 8'h07};
    localparam logic [31:0] ID [8] = '{32'h05000102, 32'h05000102, 32'h05000102, 32'h06000102,
        32'hFF000102, 32'h0, 32'h0, 32'h05010902};
    localparam logic [7:0] E1 [8] = '{8'h00, 8'h10, 8'h20, 8'h00, 8'h00, 8'h01, 8'h00, 8'h04};
    localparam logic [7:0] E2 [8] = '{8'h00, 8'h00, 8'h20, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00};
    logic i_clock, i_rst, i_soft_rst, fast, no_am, cmd_wr, result_rd, res_valid, irq, busy;
    logic side, seek_req, sep_en, xfer, dd, precomp, perp;
    logic [7:0] cmd_data, res_data, ev;
    logic [31:0] id;
    logic [1:0] drive_sel;
    logic [5:0] gap_fmt, gap_wr;
    int mismatches, n_tests, cycles;
    fdcpm_host host (.i_clock(i_clock), .i_result_valid(res_valid), .i_result_data(res_data),
        .o_cmd_wr(cmd_wr), .o_cmd_data(cmd_data), .o_result_rd(result_rd));
    fdcpm_cmd #(.DBP_CYCLES(4), .SETTLE_CYCLES(4)) DUT (.i_clock(i_clock), .i_rst(i_rst),
        .i_soft_rst(i_soft_rst), .i_cmd_wr(cmd_wr), .i_cmd_data(cmd_data),
        .i_result_rd(result_rd), .i_fast_rate(fast), .i_seek_done(ev[0]), .i_id_valid(ev[1]),
        .i_id_track(id[31:24]), .i_id_head(id[23:16]), .i_id_sector(id[15:8]),
        .i_id_size(id[7:0]), .i_index_pulse(ev[2]), .i_data_deleted(ev[3]),
        .i_sector_done(ev[4]), .i_dma_tc(ev[5]), .i_overrun(ev[6]), .i_crc_err(ev[7]),
        .i_no_am(no_am), .o_result_valid(res_valid), .o_result_data(res_data),
        .o_controller_irq(irq), .o_busy(busy), .o_side_select_out(side),
        .o_drive_sel(drive_sel), .o_seek_req(seek_req), .o_sep_enable(sep_en),
        .o_sector_xfer(xfer), .o_double_density_enc(dd), .o_gap2_fmt(gap_fmt),
        .o_gap2_wr(gap_wr), .o_precomp_zero(precomp), .o_drive_perp(perp));
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int k);
        @(negedge i_clock);
        ev[k] = 1'b1;
        @(negedge i_clock);
        ev[k] = 1'b0;
    endtask
    // Bounded, so a missing handshake ends as a mismatch, not a hang
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 500) begin
            @(negedge i_clock);
            n++;
        end
        check({7'h00, s}, 8'h01);
    endtask
    task automatic hw_reset;
        @(negedge i_clock);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clock);
        i_rst = 1'b0;
    endtask
    task automatic expect_mode(input logic [5:0] f, input logic [5:0] w);
        repeat (4) @(negedge i_clock);
        check({2'b00, gap_fmt}, {2'b00, f});
        check({2'b00, gap_wr}, {2'b00, w});
        check({6'h00, perp, precomp}, {6'h00, {2{w != 6'h00}}});
    endtask
    task automatic t_ident;
        logic [7:0] b;
        host.send(fdcpm_pkg::OPC_VERSION);
        host.recv(b);
        check(b, {fdcpm_pkg::VERSION_HIGH[7:4], fdcpm_pkg::VERSION_LOW});
        host.send(8'h07);
        host.recv(b);
        check(b, fdcpm_pkg::INVALID_RESULT);
    endtask
    task automatic t_mode;
        for (int k = 0; k < 8; k++) begin
            fast = FAST[k];
            host.send(fdcpm_pkg::OPC_DRIVE_MODE);
            host.send(CFG[k]);
            expect_mode(FMT[k], WR[k]);
        end
        fast = 1'b1;
        @(negedge i_clock);
        i_soft_rst = 1'b1;
        @(negedge i_clock);
        i_soft_rst = 1'b0;
        expect_mode(6'h29, 6'h26);
        hw_reset();
        expect_mode(6'h16, 6'h00);
    endtask
    task automatic t_read;
        logic [7:0] r [7];
        host.send(fdcpm_pkg::OPC_DRIVE_MODE);
        host.send(8'h90);
        for (int k = 0; k < 8; k++) begin
            host.read_cmd(OP[k], B2[k], 8'h05);
            repeat (2) @(negedge i_clock);
            check({3'h0, dd, side, perp, drive_sel},
                {3'h0, OP[k][6], B2[k][2], B2[k][1:0] == 2'h2, B2[k][1:0]});
            if (B2[k][7]) begin
                wait_hi(seek_req);
                pulse(0);
            end
            wait_hi(sep_en);
            no_am = (k == 5);
            if (k == 0) begin
                id = 32'h05010902;
                pulse(1);
            end
            if (ID[k] != 32'h0) begin
                id = ID[k];
                pulse(1);
            end
            if (k < 3) begin
                wait_hi(xfer);
                if (k == 0) begin
                    pulse(3);
                    id = 32'h05010102;
                    pulse(1);
                    wait_hi(xfer);
                end
                pulse(5 + k);
            end else if (k == 6) begin
                host.send(8'h00);
            end else begin
                repeat (2) pulse(2);
            end
            wait_hi(res_valid);
            check({7'h00, irq}, 8'h01);
            for (int j = 0; j < 7; j++) begin
                host.recv(r[j]);
            end
            check({6'h00, r[0][7:6]}, {7'h00, k != 0});
            check(r[1] & E1[k], E1[k]);
            check(r[2] & (E2[k] | {3'h0, k == 4, 4'h0}), E2[k]);
        end
    endtask
    initial begin
        i_rst = 1'b1;
        i_soft_rst = 1'b0;
        fast = 1'b0;
        no_am = 1'b0;
        ev = 8'h00;
        id = 32'h0;
        repeat (2) @(negedge i_clock);
        i_rst = 1'b0;
        t_ident();
        t_mode();
        t_read();
        stop_test();
    end
endmodule
`default_nettype wire
